// [brc_mem_model.sv]
`timescale 1ns/10ps
module brc_mem_model (
    input  wire logic              mclk,
    input  wire brc_pkg::brc_mem_s mem,
    output logic [15:0]            mem_rdata
);
    import brc_pkg::*;
    logic [15:0] words [16];
    initial mem_rdata = 16'h0000;
    always @(posedge mclk) begin
        if (mem.wr) begin
            words[mem.addr[3:0]] <= mem.wdata;
        end
        // Junk that changes every cycle outside a read
        mem_rdata <= mem.rd ? words[mem.addr[3:0]] : ~mem_rdata;
    end
endmodule : brc_mem_model

// [brc_ones_count.sv]
`timescale 1ns/10ps
module brc_ones_count (
    input  wire logic [brc_pkg::DWORD_W-1:0] value,
    output logic      [brc_pkg::COUNT_W-1:0] count
);
    import brc_pkg::*;

    always_comb begin
        count = '0;
        for (int i = 0; i < DWORD_W; i++) begin
            count = count + COUNT_W'(value[i]);
        end
    end

endmodule : brc_ones_count

// [brc_pkg.sv]
package brc_pkg;

    localparam int WORD_W   = 16;
    localparam int DWORD_W  = 32;
    localparam int SHIFT_W  = 6;
    localparam int COUNT_W  = 6;
    localparam int ADDR_W   = 16;
    localparam int DIGIT_W  = 4;
    localparam int RING17   = 17;
    localparam int RING33   = 33;
    localparam int BITPOS_W = 4;

    localparam logic [WORD_W-1:0]  WORD_RST  = 16'h0000;
    localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;

    typedef enum logic [3:0] {
        word_rotate_right,
        word_rotate_left,
        word_rotate_right_thru_carry,
        word_rotate_left_thru_carry,
        dword_rotate_right,
        dword_rotate_left,
        dword_rotate_right_thru_carry,
        dword_rotate_left_thru_carry,
        bit_force_one,
        bit_force_zero,
        bit_flip,
        bit_probe,
        word_ones_count,
        dword_ones_count,
        range_digit_shift_left
    } brc_op_e;

    typedef struct packed {
        logic                start;
        brc_op_e             op;
        logic [WORD_W-1:0]   opnd_lo;
        logic [WORD_W-1:0]   opnd_hi;
        logic [SHIFT_W-1:0]  n;
        logic                carry_flag;
    } brc_req_s;

    typedef struct packed {
        logic                done;
        logic [WORD_W-1:0]   res_lo;
        logic [WORD_W-1:0]   res_hi;
        logic                carry_flag;
        logic                test_result_flag;
    } brc_resp_s;

    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [ADDR_W-1:0]   addr;
        logic [WORD_W-1:0]   wdata;
    } brc_mem_s;

endpackage : brc_pkg

// [brc_unit.sv]
`timescale 1ns/10ps
module brc_unit (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire brc_pkg::brc_req_s req,
    output brc_pkg::brc_resp_s     resp,
    output brc_pkg::brc_mem_s      mem,
    input  wire logic [15:0]       mem_rdata
);
    import brc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DATA,
        ST_WRITE
    } brc_state_e;

    typedef struct packed {
        brc_state_e          st;
        brc_resp_s           resp;
        brc_mem_s            mem;
        logic [ADDR_W-1:0]   last;
        logic [DIGIT_W-1:0]  carry_digit;
    } brc_all_s;

    brc_all_s state_reg;
    brc_all_s state_next;

    logic [COUNT_W-1:0] ones;
    logic [DWORD_W-1:0] count_src;

    function automatic logic [WORD_W-1:0] bit_mask(input logic [BITPOS_W-1:0] pos);
        bit_mask = WORD_W'(1) << pos;
    endfunction : bit_mask

    assign count_src = (req.op == dword_ones_count) ? {req.opnd_hi, req.opnd_lo}
                                                    : {WORD_RST, req.opnd_lo};

    brc_ones_count u_count (
        .value (count_src),
        .count (ones)
    );

    logic [3:0]          k16;
    logic [4:0]          k32;
    logic [4:0]          k17;
    logic [5:0]          k33;
    logic [2*WORD_W-1:0] w2;
    logic [2*RING17-1:0] r17;
    logic [2*DWORD_W-1:0] d2;
    logic [2*RING33-1:0] r33;
    logic [WORD_W-1:0]   mask;

    always_comb begin
        k16  = req.n[3:0];
        k32  = req.n[4:0];
        k17  = 5'(req.n % SHIFT_W'(RING17));
        k33  = 6'(req.n % SHIFT_W'(RING33));
        w2   = {req.opnd_lo, req.opnd_lo};
        r17  = {req.carry_flag, req.opnd_lo, req.carry_flag, req.opnd_lo};
        d2   = {req.opnd_hi, req.opnd_lo, req.opnd_hi, req.opnd_lo};
        r33  = {req.carry_flag, req.opnd_hi, req.opnd_lo,
                req.carry_flag, req.opnd_hi, req.opnd_lo};
        mask = bit_mask(req.n[3:0]);
    end

    logic [2*WORD_W-1:0]  w2_r;
    logic [2*WORD_W-1:0]  w2_l;
    logic [2*RING17-1:0]  r17_r;
    logic [2*RING17-1:0]  r17_l;
    logic [2*DWORD_W-1:0] d2_r;
    logic [2*DWORD_W-1:0] d2_l;
    logic [2*RING33-1:0]  r33_r;
    logic [2*RING33-1:0]  r33_l;

    assign w2_r  = w2 >> k16;
    assign w2_l  = w2 << k16;
    assign r17_r = r17 >> k17;
    assign r17_l = r17 << k17;
    assign d2_r  = d2 >> k32;
    assign d2_l  = d2 << k32;
    assign r33_r = r33 >> k33;
    assign r33_l = r33 << k33;

    always_comb begin
        state_next           = state_reg;
        state_next.resp.done = 1'b0;
        state_next.mem.rd    = 1'b0;
        state_next.mem.wr    = 1'b0;
        case (state_reg.st)
            ST_IDLE: begin
                if (req.start) begin
                    state_next.resp.res_hi = req.opnd_hi;
                    state_next.resp.done   = 1'b1;
                    case (req.op)
                        word_rotate_right: begin
                            state_next.resp.res_lo = w2_r[WORD_W-1:0];
                        end
                        word_rotate_left: begin
                            state_next.resp.res_lo = w2_l[2*WORD_W-1:WORD_W];
                        end
                        word_rotate_right_thru_carry: begin
                            {state_next.resp.carry_flag, state_next.resp.res_lo} =
                                r17_r[RING17-1:0];
                        end
                        word_rotate_left_thru_carry: begin
                            {state_next.resp.carry_flag, state_next.resp.res_lo} =
                                r17_l[2*RING17-1:RING17];
                        end
                        dword_rotate_right: begin
                            {state_next.resp.res_hi, state_next.resp.res_lo} =
                                d2_r[DWORD_W-1:0];
                        end
                        dword_rotate_left: begin
                            {state_next.resp.res_hi, state_next.resp.res_lo} =
                                d2_l[2*DWORD_W-1:DWORD_W];
                        end
                        dword_rotate_right_thru_carry: begin
                            {state_next.resp.carry_flag, state_next.resp.res_hi,
                             state_next.resp.res_lo} = r33_r[RING33-1:0];
                        end
                        dword_rotate_left_thru_carry: begin
                            {state_next.resp.carry_flag, state_next.resp.res_hi,
                             state_next.resp.res_lo} = r33_l[2*RING33-1:RING33];
                        end
                        bit_force_one: begin
                            state_next.resp.res_lo = req.opnd_lo | mask;
                        end
                        bit_force_zero: begin
                            state_next.resp.res_lo = req.opnd_lo & ~mask;
                        end
                        bit_flip: begin
                            state_next.resp.res_lo = req.opnd_lo ^ mask;
                        end
                        bit_probe: begin
                            state_next.resp.res_lo           = req.opnd_lo;
                            state_next.resp.test_result_flag = |(req.opnd_lo & mask);
                        end
                        word_ones_count: begin
                            state_next.resp.res_lo = WORD_W'(ones);
                        end
                        dword_ones_count: begin
                            state_next.resp.res_lo = WORD_W'(ones);
                        end
                        range_digit_shift_left: begin
                            state_next.resp.res_lo = WORD_RST;
                            if (req.opnd_lo <= req.opnd_hi) begin
                                state_next.resp.done   = 1'b0;
                                state_next.mem.rd      = 1'b1;
                                state_next.mem.addr    = req.opnd_lo;
                                state_next.last        = req.opnd_hi;
                                state_next.carry_digit = DIGIT_RST;
                                state_next.st          = ST_WAIT;
                            end
                        end
                        default: begin
                            state_next.resp.res_lo = req.opnd_lo;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                state_next.st = ST_DATA;
            end
            ST_DATA: begin
                state_next.mem.wr      = 1'b1;
                state_next.mem.wdata   = {mem_rdata[WORD_W-DIGIT_W-1:0],
                                          state_reg.carry_digit};
                state_next.carry_digit = mem_rdata[WORD_W-1:WORD_W-DIGIT_W];
                state_next.st          = ST_WRITE;
            end
            ST_WRITE: begin
                if (state_reg.mem.addr == state_reg.last) begin
                    state_next.resp.done   = 1'b1;
                    state_next.resp.res_lo = WORD_W'(state_reg.carry_digit);
                    state_next.st          = ST_IDLE;
                end else begin
                    state_next.mem.addr = state_reg.mem.addr + ADDR_W'(1);
                    state_next.mem.rd   = 1'b1;
                    state_next.st       = ST_WAIT;
                end
            end
            default: begin
                state_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign resp = state_reg.resp;
    assign mem  = state_reg.mem;

endmodule : brc_unit

// [brc_unit_chk.sv]
`timescale 1ns/10ps
module brc_unit_chk (
    input wire logic               mclk,
    input wire logic               rst,
    input wire brc_pkg::brc_req_s  req,
    input wire brc_pkg::brc_resp_s resp,
    input wire brc_pkg::brc_mem_s  mem,
    input wire logic [15:0]        mem_rdata
);
    import brc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic        single;
    logic        probe_bit;
    logic [15:0] rot_r;
    logic [31:0] twice;
    assign single    = req.start && req.op != range_digit_shift_left;
    assign probe_bit = req.opnd_lo[req.n[3:0]];
    assign twice     = {req.opnd_lo, req.opnd_lo} >> (req.n % 16);
    assign rot_r     = twice[15:0];
    a_done_single: assert property (single |=> resp.done)
        else $error("done missing after start");
    a_done_cause: assert property (resp.done |-> $past(req.start) || $past(mem.wr))
        else $error("done without cause");
    a_rotr_word: assert property (req.start && req.op == word_rotate_right
        |=> resp.res_lo == $past(rot_r)) else $error("word rotate wrong");
    a_probe_flag: assert property (req.start && req.op == bit_probe
        |=> resp.test_result_flag == $past(probe_bit)) else $error("probe flag wrong");
    a_probe_kept: assert property (single && req.op != bit_probe
        |=> $stable(resp.test_result_flag)) else $error("test flag moved");
    a_force_one: assert property (req.start && req.op == bit_force_one
        |=> resp.res_lo == ($past(req.opnd_lo) | (16'h0001 << $past(req.n[3:0]))))
        else $error("bit set wrong");
    a_count_word: assert property (req.start && req.op == word_ones_count
        |=> resp.res_lo == 16'($countones($past(req.opnd_lo)))) else $error("count wrong");
    a_carry_kept: assert property (req.start && req.op inside {word_rotate_right,
        word_rotate_left, dword_rotate_right, dword_rotate_left}
        |=> $stable(resp.carry_flag)) else $error("carry moved");
    a_mem_order: assert property (mem.rd |=> $stable(mem.addr) && !mem.wr
        ##1 $stable(mem.addr) && mem.wr) else $error("memory order wrong");
endmodule : brc_unit_chk

bind brc_unit brc_unit_chk u_chk (.mclk(mclk), .rst(rst), .req(req), .resp(resp),
    .mem(mem), .mem_rdata(mem_rdata));

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import brc_pkg::*;
    logic      mclk;
    logic      rst;
    brc_req_s  req;
    brc_resp_s resp;
    brc_mem_s  mem;
    logic [15:0] mem_rdata;
    int   fails;
    int   n_tests;
    int   cycles = 0;
    int   lat;
    logic exp_c;
    logic exp_t;

    brc_unit dut (.mclk(mclk), .rst(rst), .req(req), .resp(resp), .mem(mem),
        .mem_rdata(mem_rdata));
    brc_mem_model u_mem (.mclk(mclk), .mem(mem), .mem_rdata(mem_rdata));

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            final_report();
        end
    end

    task automatic final_report;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic run(input int op, input logic [15:0] lo, input logic [15:0] hi,
                       input logic [5:0] n, input logic c);
        req = '{1'b1, brc_op_e'(op), lo, hi, n, c};
        @(negedge mclk);
        req.start = 1'b0;
        // Done may already stand right after the taking edge
        lat = 1;
        while (resp.done !== 1'b1 && lat < 200) begin
            @(negedge mclk);
            lat++;
        end
        // One idle edge so the next start does not follow a falling start
        @(negedge mclk);
    endtask : run

    function automatic logic [32:0] ring(input logic [32:0] v, input int w, input int k);
        logic [32:0] r;
        r = v;
        for (int i = 0; i < w; i++)
            r[i] = v[(i + k) % w];
        return r;
    endfunction : ring

    task automatic t_rotate;
        logic [5:0]  nv [4] = '{6'h00, 6'h01, 6'h10, 6'h3F};
        logic [15:0] lo;
        logic [15:0] hi;
        logic [32:0] r;
        int w;
        for (int o = 0; o < 8; o++) begin
            foreach (nv[j]) begin
                lo = 16'hA5C3 ^ 16'(o);
                hi = 16'h1E87;
                w = o[2] ? (o[1] ? 33 : 32) : (o[1] ? 17 : 16);
                r = {j[0], hi, lo};
                if (w < 32)
                    r = {16'h0000, w == 17 && j[0], lo};
                else if (w == 32)
                    r[32] = 1'b0;
                r = ring(r, w, o[0] ? w - nv[j] % w : nv[j] % w);
                run(o, lo, hi, nv[j], j[0]);
                chk(resp.res_lo, r[15:0]);
                chk(resp.res_hi, o[2] ? r[31:16] : hi);
                if (o[1])
                    exp_c = r[w-1];
                chk(resp.carry_flag, exp_c);
                chk(lat, 1);
            end
        end
    endtask : t_rotate

    task automatic t_bits;
        logic [5:0]  nv [4] = '{6'h00, 6'h07, 6'h0F, 6'h15};
        logic [15:0] lo = 16'h8A31;
        logic [15:0] b;
        logic [15:0] e [4];
        for (int o = 8; o < 12; o++) begin
            foreach (nv[j]) begin
                b = 16'h0001 << nv[j][3:0];
                e = '{lo | b, lo & ~b, lo ^ b, lo};
                if (o == 11)
                    exp_t = |(lo & b);
                run(o, lo, 16'h0000, nv[j], 1'b0);
                chk(resp.res_lo, e[o-8]);
                chk(resp.test_result_flag, exp_t);
            end
        end
    endtask : t_bits

    task automatic t_count;
        logic [31:0] v [3] = '{32'h0, 32'hFFFFFFFF, 32'h0F0F8A31};
        foreach (v[j]) begin
            run(12, v[j][15:0], v[j][31:16], 6'h00, 1'b0);
            chk(resp.res_lo, $countones(v[j][15:0]));
            run(13, v[j][15:0], v[j][31:16], 6'h00, 1'b0);
            chk(resp.res_lo, $countones(v[j]));
        end
    endtask : t_count

    task automatic t_range;
        logic [15:0] old [16];
        foreach (old[i]) begin
            old[i] = 16'h1234 + 16'(i) * 16'h1111;
            u_mem.words[i] = old[i];
        end
        run(14, 16'h0002, 16'h0005, 6'h00, 1'b0);
        chk(lat, 13);
        chk(resp.res_lo, old[5][15:12]);
        for (int i = 1; i < 7; i++)
            chk(u_mem.words[i], (i < 2 || i > 5) ? old[i] :
                {old[i][11:0], i == 2 ? 4'h0 : old[i-1][15:12]});
        run(14, 16'h0006, 16'h0005, 6'h00, 1'b0);
        chk(lat, 1);
        chk(u_mem.words[6], old[6]);
    endtask : t_range

    initial begin
        req   = '0;
        exp_c = 1'b0;
        exp_t = 1'b0;
        rst   = 1'b1;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        chk({resp.done, resp.res_lo, resp.carry_flag}, 0);
        t_rotate();
        t_bits();
        t_count();
        t_range();
        final_report();
    end
endmodule : tb_top
